// File: verilog/poll_flags_pkg.sv
// constants, register map and carrier types for the poll wakeup and flag block
package poll_flags_pkg;
   // register offsets on the serial register port
   localparam logic [7:0] ADDR_INTERRUPT_FLAGS = 8'h15;
   localparam logic [7:0] ADDR_POLL_WAKEUP_INTERVAL = 8'h16;
   localparam logic [7:0] ADDR_POLL_ACTION_CONFIG = 8'h17;

   // reset values
   localparam logic [7:0] FLAGS_RST = 8'h01;
   localparam logic [7:0] INTERVAL_RST = 8'hff;
   localparam logic [7:0] ACTION_RST = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // interrupt flag bit positions
   localparam int FLAG_RX_READY_BIT = 7;
   localparam int FLAG_EOF_BIT = 6;
   localparam int FLAG_PREAMBLE_BIT = 5;
   localparam int FLAG_WAKEUP_BIT = 4;
   localparam int FLAG_POLL_BIT = 3;
   localparam int FLAG_WATCHDOG_BIT = 2;
   localparam int FLAG_UNDERVOLT_BIT = 1;
   localparam int FLAG_POR_BIT = 0;

   // poll action config field positions
   localparam int ACT_MODE_HI = 7;
   localparam int ACT_MODE_LO = 6;
   localparam int ACT_CHAN_HI = 5;
   localparam int ACT_CHAN_LO = 4;
   localparam int ACT_KIND_BIT = 3;
   localparam int ACT_GAIN_TWO = 2;
   localparam int ACT_GAIN_ONE = 1;
   localparam int ACT_SET_FLAGS_BIT = 0;

   // post-event modes
   localparam logic [1:0] MODE_STAY_DOWN = 2'h0;
   localparam logic [1:0] MODE_REF_OSC = 2'h1;
   localparam logic [1:0] MODE_RX_UP = 2'h2;
   localparam logic [1:0] MODE_RX_AUTO = 2'h3;

   // wakeup tick timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SHORT_TICK_MS = 1;
   localparam int NS_PER_MS = 1000000;
   localparam int SHORT_TICK_CYCLES_DEF = (SHORT_TICK_MS * NS_PER_MS) / CLK_PERIOD_NS;
   localparam int LONG_TICK_MULT = 16;
   localparam int PRESCALE_W = 24;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // register port request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   // receive flags handed to the receive command logic
   typedef struct packed {
      logic rx_channel_bit_hi;
      logic rx_channel_bit_lo;
      logic rx_kind_bit;
      logic rx_subcmd_bit;
      logic rx_gain_bit_two;
      logic rx_gain_bit_one;
   } rx_flags_s;
endpackage

// File: verilog/poll_wakeup_and_irq_flags.sv
// sticky interrupt flags, polling wakeup timer and automatic post-wakeup action
// Summary of operation
// RQ1: each flag latches on its event and holds until the flag register is read
// RQ2: a flag register read returns the latched flags then clears them all
// RQ3: bit 7 sets when the start-up sequence into receive mode completes
// RQ4: bit 5 sets on successful preamble detection, not maskable
// RQ5: bit 4 sets on successful wakeup search, not maskable
// RQ6: bit 3 sets on every polling timer event, not maskable
// RQ7: bit 0 resets to one and sets on a software device reset
// RQ8: polling interval is wakeup field plus one times the tick period
// RQ9: tick period is 1 ms with long select low, 16 ms with it high
// RQ10: action bits 7:6 choose the mode entered after each polling event
// RQ11: action bits 5:4 carry channel select for the automatic receive command
// RQ12: action bit 3 picks wakeup search (0) or preamble detection (1)
// RQ13: action bits 2:1 carry the gain step and switch selection
// RQ14: with action bit 0 low the receive flags are used unchanged
// RQ15: with action bit 0 high fields are copied into receive flags before launch
// RQ16: whenever receive flags are overwritten the sub-command flag is forced to one
// RQ17: modes: stay down, start oscillator, power to receive, power and auto launch
// RQ18: the long tick select input comes from clock register bit 5, default zero
// RQ19: after reset with the disable pin low the timer runs at 256 short ticks (field 255)
// RQ20: an event in the cycle of a flag read survives the read clear
// RQ21: the polling counter reloads after each event and keeps running periodically
`timescale 1ns/100ps
module poll_wakeup_and_irq_flags #(
   parameter int unsigned SHORT_TICK_CYCLES = poll_flags_pkg::SHORT_TICK_CYCLES_DEF
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire poll_flags_pkg::reg_req_s reg_req_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   input wire logic rx_ready_evt_in,
   input wire logic eof_evt_in,
   input wire logic preamble_ok_in,
   input wire logic wakeup_ok_in,
   input wire logic watchdog_evt_in,
   input wire logic undervoltage_in,
   input wire logic sw_reset_in,
   input wire logic long_tick_select_in,
   input wire logic poll_enable_wr_in,
   input wire logic poll_enable_val_in,
   input wire logic reset_disable_pin_in,
   output logic poll_timer_running_out,
   output logic poll_event_out,
   output logic [1:0] poll_mode_out,
   output logic wake_ref_osc_out,
   output logic wake_rx_out,
   output logic rx_flags_wr_out,
   output poll_flags_pkg::rx_flags_s rx_flags_out,
   output logic auto_rx_launch_out,
   output logic auto_launch_preamble_out
);
   typedef enum logic [1:0] {auto_idle, auto_wait_rx, auto_write, auto_launch} auto_state_e;

   localparam logic [poll_flags_pkg::PRESCALE_W-1:0] SHORT_LAST =
      poll_flags_pkg::PRESCALE_W'(SHORT_TICK_CYCLES - 1);
   localparam logic [poll_flags_pkg::PRESCALE_W-1:0] LONG_LAST =
      poll_flags_pkg::PRESCALE_W'(SHORT_TICK_CYCLES * poll_flags_pkg::LONG_TICK_MULT - 1);

   logic [7:0] flags_ff;
   logic [7:0] nxt_flags;
   logic [7:0] flag_set;
   logic [7:0] interval_ff;
   logic [7:0] action_ff;
   logic [7:0] rdata_ff;
   logic rvalid_ff;
   logic pin_meta_ff;
   logic pin_sync_ff;
   logic [1:0] strap_cnt_ff;
   logic strap_done_ff;
   logic run_ff;
   logic [poll_flags_pkg::PRESCALE_W-1:0] prescale_ff;
   logic [7:0] tick_cnt_ff;
   logic tick;
   logic poll_evt;
   logic event_ff;
   logic wake_osc_ff;
   logic wake_rx_ff;
   auto_state_e auto_state_ff;
   auto_state_e nxt_auto_state;
   poll_flags_pkg::rx_flags_s rx_flags_ff;
   logic rd_flags;

   // register address decode helper, shared by read and write paths
   function automatic logic hit(input poll_flags_pkg::reg_req_s req, input logic [7:0] addr);
      hit = req.addr == addr;
   endfunction

   assign rd_flags = reg_req_in.rd && hit(reg_req_in, poll_flags_pkg::ADDR_INTERRUPT_FLAGS);

   // event sources gathered into the flag positions
   always_comb begin
      flag_set = poll_flags_pkg::ZERO_BYTE;
      flag_set[poll_flags_pkg::FLAG_RX_READY_BIT] = rx_ready_evt_in; // [RQ3]
      flag_set[poll_flags_pkg::FLAG_EOF_BIT] = eof_evt_in;
      flag_set[poll_flags_pkg::FLAG_PREAMBLE_BIT] = preamble_ok_in; // [RQ4]
      flag_set[poll_flags_pkg::FLAG_WAKEUP_BIT] = wakeup_ok_in; // [RQ5]
      flag_set[poll_flags_pkg::FLAG_POLL_BIT] = poll_evt; // [RQ6]
      flag_set[poll_flags_pkg::FLAG_WATCHDOG_BIT] = watchdog_evt_in;
      flag_set[poll_flags_pkg::FLAG_UNDERVOLT_BIT] = undervoltage_in;
      flag_set[poll_flags_pkg::FLAG_POR_BIT] = sw_reset_in; // [RQ7]
   end

   // read clears, but a same-cycle event is ORed in after so it wins
   always_comb begin
      nxt_flags = (rd_flags ? '0 : flags_ff) | flag_set; // [RQ1] [RQ2] [RQ20]
   end

   // masking lives in the enable register outside, so these flags stay raw
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         flags_ff <= poll_flags_pkg::FLAGS_RST; // [RQ7]
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // read data is registered; unmapped addresses read zero
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_ff <= poll_flags_pkg::ZERO_BYTE;
         rvalid_ff <= 1'h0;
      end else begin
         rvalid_ff <= reg_req_in.rd;
         if (reg_req_in.rd) begin
            if (rd_flags) begin
               rdata_ff <= flags_ff; // [RQ2]
            end else if (hit(reg_req_in, poll_flags_pkg::ADDR_POLL_WAKEUP_INTERVAL)) begin
               rdata_ff <= interval_ff;
            end else if (hit(reg_req_in, poll_flags_pkg::ADDR_POLL_ACTION_CONFIG)) begin
               rdata_ff <= action_ff;
            end else begin
               rdata_ff <= poll_flags_pkg::ZERO_BYTE;
            end
         end
      end
   end

   // writable configuration; the flag register ignores writes
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || sw_reset_in) begin
         interval_ff <= poll_flags_pkg::INTERVAL_RST; // [RQ19]
         action_ff <= poll_flags_pkg::ACTION_RST;
      end else if (reg_req_in.wr) begin
         if (hit(reg_req_in, poll_flags_pkg::ADDR_POLL_WAKEUP_INTERVAL)) begin
            interval_ff <= reg_req_in.wdata;
         end
         if (hit(reg_req_in, poll_flags_pkg::ADDR_POLL_ACTION_CONFIG)) begin
            action_ff <= reg_req_in.wdata;
         end
      end
   end

   // the strap pin is asynchronous, so two flops before anything looks at it
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin_meta_ff <= 1'h0;
         pin_sync_ff <= 1'h0;
      end else begin
         pin_meta_ff <= reset_disable_pin_in;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // strap is caught once the synchroniser has settled after release
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         strap_cnt_ff <= 2'h0;
         strap_done_ff <= 1'h0;
         run_ff <= 1'h0;
      end else if (!strap_done_ff) begin
         strap_cnt_ff <= strap_cnt_ff + 2'h1;
         if (strap_cnt_ff == poll_flags_pkg::STRAP_SETTLE) begin
            strap_done_ff <= 1'h1;
            run_ff <= ~pin_sync_ff; // [RQ19]
         end
      end else if (poll_enable_wr_in) begin
         run_ff <= poll_enable_val_in;
      end
   end

   // tick prescaler; >= keeps a range switch mid-tick from overrunning
   assign tick = prescale_ff >= (long_tick_select_in ? LONG_LAST : SHORT_LAST); // [RQ9] [RQ18]
   assign poll_evt = run_ff && tick && (tick_cnt_ff >= interval_ff); // [RQ8]

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !run_ff) begin
         prescale_ff <= '0;
         tick_cnt_ff <= 8'h00;
      end else if (tick) begin
         prescale_ff <= '0;
         tick_cnt_ff <= poll_evt ? 8'h00 : tick_cnt_ff + 8'h01; // [RQ21]
      end else begin
         prescale_ff <= prescale_ff + 1'h1;
      end
   end

   // post-event wake requests, one registered pulse per event
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         event_ff <= 1'h0;
         wake_osc_ff <= 1'h0;
         wake_rx_ff <= 1'h0;
      end else begin
         event_ff <= poll_evt;
         wake_osc_ff <= poll_evt && (poll_mode_out == poll_flags_pkg::MODE_REF_OSC); // [RQ17]
         wake_rx_ff <= poll_evt && poll_mode_out[1]; // [RQ17]
      end
   end

   // auto launch waits for receive ready; a new event while busy is dropped
   always_comb begin
      nxt_auto_state = auto_state_ff;
      case (auto_state_ff)
         auto_idle: begin
            if (poll_evt && poll_mode_out == poll_flags_pkg::MODE_RX_AUTO) begin
               nxt_auto_state = auto_wait_rx; // [RQ17]
            end
         end
         auto_wait_rx: begin
            if (rx_ready_evt_in) begin
               nxt_auto_state = action_ff[poll_flags_pkg::ACT_SET_FLAGS_BIT] ?
                  auto_write : auto_launch; // [RQ14] [RQ15]
            end
         end
         auto_write: nxt_auto_state = auto_launch;
         auto_launch: nxt_auto_state = auto_idle;
         default: nxt_auto_state = auto_idle;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || sw_reset_in) begin
         auto_state_ff <= auto_idle;
      end else begin
         auto_state_ff <= nxt_auto_state;
      end
   end

   // receive flag image loaded on the same edge that raises the write strobe
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rx_flags_ff <= '0;
      end else if (auto_state_ff == auto_wait_rx && nxt_auto_state == auto_write) begin
         rx_flags_ff.rx_channel_bit_hi <= action_ff[poll_flags_pkg::ACT_CHAN_HI]; // [RQ11]
         rx_flags_ff.rx_channel_bit_lo <= action_ff[poll_flags_pkg::ACT_CHAN_LO]; // [RQ11]
         rx_flags_ff.rx_kind_bit <= action_ff[poll_flags_pkg::ACT_KIND_BIT]; // [RQ12]
         rx_flags_ff.rx_subcmd_bit <= 1'h1; // [RQ16]
         rx_flags_ff.rx_gain_bit_two <= action_ff[poll_flags_pkg::ACT_GAIN_TWO]; // [RQ13]
         rx_flags_ff.rx_gain_bit_one <= action_ff[poll_flags_pkg::ACT_GAIN_ONE]; // [RQ13]
      end
   end

   assign reg_rdata_out = rdata_ff;
   assign reg_rvalid_out = rvalid_ff;
   assign poll_timer_running_out = run_ff;
   assign poll_event_out = event_ff;
   assign poll_mode_out =
      action_ff[poll_flags_pkg::ACT_MODE_HI:poll_flags_pkg::ACT_MODE_LO]; // [RQ10]
   assign wake_ref_osc_out = wake_osc_ff;
   assign wake_rx_out = wake_rx_ff;
   assign rx_flags_wr_out = auto_state_ff == auto_write; // [RQ15]
   assign rx_flags_out = rx_flags_ff;
   assign auto_rx_launch_out = auto_state_ff == auto_launch;
   assign auto_launch_preamble_out = action_ff[poll_flags_pkg::ACT_KIND_BIT]; // [RQ12]

   // helper: cycles between polling events while configuration holds still
   logic [31:0] gap_ff;
   logic gap_valid_ff;
   logic [31:0] expect_gap;
   assign expect_gap = (32'(interval_ff) + 32'h1) *
      (long_tick_select_in ? 32'(SHORT_TICK_CYCLES * poll_flags_pkg::LONG_TICK_MULT) :
      32'(SHORT_TICK_CYCLES)) - 32'h1;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !run_ff || reg_req_in.wr || poll_enable_wr_in || sw_reset_in ||
          (long_tick_select_in != $past(long_tick_select_in))) begin
         gap_ff <= 32'h0;
         gap_valid_ff <= 1'h0;
      end else if (poll_evt) begin
         gap_ff <= 32'h0;
         gap_valid_ff <= 1'h1;
      end else begin
         gap_ff <= gap_ff + 32'h1;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_read_returns;
      rd_flags |=> reg_rvalid_out && reg_rdata_out == $past(flags_ff);
   endproperty
   a_read_returns: assert property (p_read_returns) else $error("flag read data wrong"); // [RQ2]

   property p_read_clears;
      rd_flags && flag_set == 8'h00 |=> flags_ff == 8'h00;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("flags not cleared"); // [RQ2]

   property p_sticky;
      !rd_flags && flags_ff[poll_flags_pkg::FLAG_EOF_BIT] |=>
         flags_ff[poll_flags_pkg::FLAG_EOF_BIT];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag lost without read"); // [RQ1]

   property p_rx_ready_flag;
      rx_ready_evt_in |=> flags_ff[poll_flags_pkg::FLAG_RX_READY_BIT];
   endproperty
   a_rx_ready_flag: assert property (p_rx_ready_flag) else $error("rx ready flag lost"); // [RQ3]

   property p_preamble_flag;
      preamble_ok_in |=> flags_ff[poll_flags_pkg::FLAG_PREAMBLE_BIT];
   endproperty
   a_preamble_flag: assert property (p_preamble_flag) else $error("preamble flag lost"); // [RQ4]

   property p_wakeup_flag;
      wakeup_ok_in |=> flags_ff[poll_flags_pkg::FLAG_WAKEUP_BIT];
   endproperty
   a_wakeup_flag: assert property (p_wakeup_flag) else $error("wakeup flag missing"); // [RQ5]

   property p_poll_flag;
      poll_evt |=> poll_event_out && flags_ff[poll_flags_pkg::FLAG_POLL_BIT];
   endproperty
   a_poll_flag: assert property (p_poll_flag) else $error("poll flag missing"); // [RQ6]

   property p_por_flag;
      sw_reset_in |=> flags_ff[poll_flags_pkg::FLAG_POR_BIT];
   endproperty
   a_por_flag: assert property (p_por_flag) else $error("reset flag missing"); // [RQ7]

   property p_read_race;
      rd_flags && undervoltage_in |=> flags_ff[poll_flags_pkg::FLAG_UNDERVOLT_BIT];
   endproperty
   a_read_race: assert property (p_read_race) else $error("event lost on read"); // [RQ20]

   property p_period;
      poll_evt && gap_valid_ff |-> gap_ff == expect_gap;
   endproperty
   a_period: assert property (p_period) else $error("poll period wrong"); // [RQ8]

   property p_osc_mode;
      poll_evt && poll_mode_out == poll_flags_pkg::MODE_REF_OSC |=>
         wake_ref_osc_out && !wake_rx_out;
   endproperty
   a_osc_mode: assert property (p_osc_mode) else $error("oscillator wake missing"); // [RQ17]

   property p_stay_down;
      poll_evt && poll_mode_out == poll_flags_pkg::MODE_STAY_DOWN |=>
         !wake_ref_osc_out && !wake_rx_out;
   endproperty
   a_stay_down: assert property (p_stay_down) else $error("wake in stay-down mode"); // [RQ10]

   property p_write_then_launch;
      rx_flags_wr_out |-> rx_flags_out.rx_subcmd_bit ##1 auto_rx_launch_out;
   endproperty
   a_write_then_launch: assert property (p_write_then_launch) else $error("bad order"); // [RQ16]

   property p_no_overwrite;
      auto_rx_launch_out && !$past(rx_flags_wr_out) |-> $past(auto_state_ff) == auto_wait_rx;
   endproperty
   a_no_overwrite: assert property (p_no_overwrite) else $error("launch path wrong"); // [RQ14]

   c_poll_event: cover property (poll_evt ##[1:20] rd_flags);
   c_auto_overwrite: cover property (rx_flags_wr_out ##1 auto_rx_launch_out);
   c_auto_plain: cover property (auto_state_ff == auto_wait_rx ##1 auto_rx_launch_out);
   c_read_race: cover property (rd_flags && flag_set != 8'h00);
endmodule

// File: verif/host_model.sv
// behavioural host that reaches the block's registers over the request port
`timescale 1ns/100ps
module host_model (
   input wire logic clk_in,
   output poll_flags_pkg::reg_req_s req_out,
   input wire logic [7:0] rdata_in,
   input wire logic rvalid_in
);
   initial begin
      req_out = '0;
   end

   // a released request shows inverted address and data, never the stale value
   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk_in);
      req_out = '{rd: 1'h0, wr: 1'h1, addr: addr, wdata: data};
      @(negedge clk_in);
      req_out = '{rd: 1'h0, wr: 1'h0, addr: ~addr, wdata: ~data};
   endtask

   // answer is registered on the taking edge itself, so it is read at the next negedge
   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      @(negedge clk_in);
      req_out = '{rd: 1'h1, wr: 1'h0, addr: addr, wdata: 8'h00};
      @(negedge clk_in);
      data = rdata_in;
      ok = rvalid_in;
      req_out = '{rd: 1'h0, wr: 1'h0, addr: ~addr, wdata: 8'hff};
   endtask
endmodule

// File: verif/poll_wakeup_and_irq_flags_bench.sv
// self-checking bench for the poll wakeup and flag block
`timescale 1ns/100ps
module poll_wakeup_and_irq_flags_bench;
   localparam int unsigned TICK = 4;
   logic clk_in = 1'h0;
   logic rst_n_in = 1'h0;
   logic [7:0] evt = 8'h00;
   logic sw_reset = 1'h0;
   logic long_sel = 1'h0;
   logic en_wr = 1'h0;
   logic en_val = 1'h0;
   logic pin = 1'h0;
   poll_flags_pkg::reg_req_s req;
   logic [7:0] rdata;
   logic rvalid;
   logic running;
   logic poll_event_out;
   logic [1:0] mode;
   logic wake_osc;
   logic wake_rx;
   logic flags_wr;
   poll_flags_pkg::rx_flags_s rx_flags;
   logic launch;
   logic launch_pre;
   int miscompares = 0;
   int total_checks = 0;

   // 100 MHz clock
   initial begin
      forever #5 clk_in = ~clk_in;
   end

   host_model host (.clk_in(clk_in), .req_out(req), .rdata_in(rdata), .rvalid_in(rvalid));

   poll_wakeup_and_irq_flags #(.SHORT_TICK_CYCLES(TICK)) uut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
      .reg_rvalid_out(rvalid), .rx_ready_evt_in(evt[7]), .eof_evt_in(evt[6]),
      .preamble_ok_in(evt[5]), .wakeup_ok_in(evt[4]), .watchdog_evt_in(evt[2]),
      .undervoltage_in(evt[1]), .sw_reset_in(sw_reset), .long_tick_select_in(long_sel),
      .poll_enable_wr_in(en_wr), .poll_enable_val_in(en_val), .reset_disable_pin_in(pin),
      .poll_timer_running_out(running), .poll_event_out(poll_event_out),
      .poll_mode_out(mode), .wake_ref_osc_out(wake_osc), .wake_rx_out(wake_rx),
      .rx_flags_wr_out(flags_wr), .rx_flags_out(rx_flags), .auto_rx_launch_out(launch),
      .auto_launch_preamble_out(launch_pre));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   // one register read, its answer strobe and data both judged
   task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host.reg_read(addr, d, ok);
      check("read strobe", {7'h00, ok}, 8'h01);
      check("read data", d, exp);
   endtask

   // event sources are one-cycle pulses launched at a falling edge
   task automatic pulse_evt(input logic [7:0] m);
      @(negedge clk_in);
      evt = m;
      @(negedge clk_in);
      evt = 8'h00;
   endtask

   task automatic set_enable(input logic v);
      @(negedge clk_in);
      en_wr = 1'h1;
      en_val = v;
      @(negedge clk_in);
      en_wr = 1'h0;
      check("timer running", {7'h00, running}, {7'h00, v});
   endtask

   // bounded wait for the next timer event; n is cycles since the call
   task automatic wait_evt(output int n);
      n = 0;
      do begin
         @(negedge clk_in);
         n++;
      end while (poll_event_out !== 1'h1 && n < 4000);
      if (n >= 4000) check("event wait", 8'h00, 8'h01);
   endtask

   task automatic test_reset();
      repeat (5) @(negedge clk_in);
      check("timer running", {7'h00, running}, 8'h01);
      rd_check(poll_flags_pkg::ADDR_INTERRUPT_FLAGS, 8'h01);
      rd_check(poll_flags_pkg::ADDR_INTERRUPT_FLAGS, 8'h00);
      rd_check(poll_flags_pkg::ADDR_POLL_WAKEUP_INTERVAL, 8'hff);
      rd_check(poll_flags_pkg::ADDR_POLL_ACTION_CONFIG, 8'h00);
      rd_check(8'h30, 8'h00);
      set_enable(1'h0);
   endtask

   // a mid-run reset with the strap pin high must leave the timer off
   task automatic test_strap();
      @(negedge clk_in);
      pin = 1'h1;
      rst_n_in = 1'h0;
      repeat (2) @(negedge clk_in);
      rst_n_in = 1'h1;
      repeat (5) @(negedge clk_in);
      check("timer running", {7'h00, running}, 8'h00);
      rd_check(poll_flags_pkg::ADDR_INTERRUPT_FLAGS, 8'h01);
      pin = 1'h0;
   endtask

   task automatic test_flags();
      logic [7:0] d;
      logic ok;
      pulse_evt(8'hf6);
      rd_check(poll_flags_pkg::ADDR_INTERRUPT_FLAGS, 8'hf6);
      rd_check(poll_flags_pkg::ADDR_INTERRUPT_FLAGS, 8'h00);
      host.reg_write(poll_flags_pkg::ADDR_INTERRUPT_FLAGS, 8'hff);
      rd_check(poll_flags_pkg::ADDR_INTERRUPT_FLAGS, 8'h00);
      // an event landing on the clearing read must survive it
      fork
         host.reg_read(poll_flags_pkg::ADDR_INTERRUPT_FLAGS, d, ok);
         pulse_evt(8'h20);
      join
      check("flags at read", d, 8'h00);
      rd_check(poll_flags_pkg::ADDR_INTERRUPT_FLAGS, 8'h20);
      host.reg_write(poll_flags_pkg::ADDR_POLL_WAKEUP_INTERVAL, 8'h5a);
      host.reg_write(poll_flags_pkg::ADDR_POLL_ACTION_CONFIG, 8'h3c);
      rd_check(poll_flags_pkg::ADDR_POLL_WAKEUP_INTERVAL, 8'h5a);
      rd_check(poll_flags_pkg::ADDR_POLL_ACTION_CONFIG, 8'h3c);
      @(negedge clk_in);
      sw_reset = 1'h1;
      @(negedge clk_in);
      sw_reset = 1'h0;
      rd_check(poll_flags_pkg::ADDR_INTERRUPT_FLAGS, 8'h01);
      rd_check(poll_flags_pkg::ADDR_POLL_WAKEUP_INTERVAL, 8'hff);
      rd_check(poll_flags_pkg::ADDR_POLL_ACTION_CONFIG, 8'h00);
   endtask

   // periods are measured between two events so the start offset drops out
   task automatic test_timer();
      int n;
      host.reg_write(poll_flags_pkg::ADDR_POLL_WAKEUP_INTERVAL, 8'h02);
      set_enable(1'h1);
      wait_evt(n);
      wait_evt(n);
      check("short period", n[7:0], 8'h0c);
      rd_check(poll_flags_pkg::ADDR_INTERRUPT_FLAGS, 8'h08);
      long_sel = 1'h1;
      wait_evt(n);
      wait_evt(n);
      check("long period", n[7:0], 8'hc0);
      long_sel = 1'h0;
      wait_evt(n);
   endtask

   task automatic test_modes();
      int n;
      for (int m = 0; m < 3; m++) begin
         host.reg_write(poll_flags_pkg::ADDR_POLL_ACTION_CONFIG, {m[1:0], 6'h00});
         wait_evt(n);
         wait_evt(n);
         check("mode", {6'h00, mode}, {6'h00, m[1:0]});
         check("wake osc", {7'h00, wake_osc}, {7'h00, m == 1});
         check("wake rx", {7'h00, wake_rx}, {7'h00, m[1]});
      end
   endtask

   // mode 3 waits for receive-ready, then optionally rewrites flags, then launches
   task automatic test_auto();
      int n;
      host.reg_write(poll_flags_pkg::ADDR_POLL_ACTION_CONFIG, 8'heb);
      check("kind", {7'h00, launch_pre}, 8'h01);
      wait_evt(n);
      wait_evt(n);
      pulse_evt(8'h80);
      check("flags write", {7'h00, flags_wr}, 8'h01);
      check("rx flags", {2'h0, rx_flags}, 8'h2d);
      check("launch early", {7'h00, launch}, 8'h00);
      @(negedge clk_in);
      check("launch", {7'h00, launch}, 8'h01);
      host.reg_write(poll_flags_pkg::ADDR_POLL_ACTION_CONFIG, 8'hc6);
      check("kind", {7'h00, launch_pre}, 8'h00);
      wait_evt(n);
      wait_evt(n);
      pulse_evt(8'h80);
      check("flags write", {7'h00, flags_wr}, 8'h00);
      check("launch", {7'h00, launch}, 8'h01);
      rd_check(poll_flags_pkg::ADDR_INTERRUPT_FLAGS, 8'h88);
      set_enable(1'h0);
   endtask

   // the whole run needs about 640 cycles; a hang is cut off by the 5000-cycle limit well above that
   initial begin
      repeat (5000) @(posedge clk_in);
      miscompares++;
      complete_run();
   end

   initial begin
      repeat (16) @(negedge clk_in);
      rst_n_in = 1'b1;
      test_reset();
      test_strap();
      test_flags();
      test_timer();
      test_modes();
      test_auto();
      complete_run();
   end
endmodule
